/* File: core/link_rx_window.sv */
// link receive window decode, lane diagnostic capture and receive configuration registers
// How it works
// R1: lanes are captured into the diagnostic register only while the sample enable bit is one.
// R2: the control lane phases go to bits 15:8, ctl0 on even and ctl1 on odd positions.
// R3: the 16-bit lane word goes to bits 31:16 of the diagnostic register.
// R4: bits 9:8 of the routing register select spread_one, spread_two or spread_four.
// R5: the data buffer credit fields at 27:24, 23:20, 19:16 reset to 0x7.
// R6: the command buffer credit fields at 15:12, 11:8, 7:4, 3:0 reset to 0x8.
// R7: an address hits when base and mask equals address and mask.
// R8: with translation on the output is translated base or the unmasked address bits, else the address.
// R9: software programs each mask as ones above zeros, the zero count giving the window size.
// R10: link addresses that hit a window are delivered to the processor side.
// R11: commands that hit no window go back onto the link as peer-to-peer commands.
// R12: the window 0 enable register at 0x60 resets to zero.
// R13: enable bit 31, translate bit 30, and bits 29:0 hold translated address bits 53:24.
// R14: base register bits 31:16 hold base and 15:0 mask, for address bits 39:24.
// R15: a disabled window never hits, so its traffic takes the peer-to-peer path.
// R16: captured lane fields refresh each link cycle while enabled and hold when disabled.
`timescale 1ns/1ps
`default_nettype none
module link_rx_window
	import link_rx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_clk,
	input wire logic link_rstn,
	input wire logic [15:0] lane_cad,
	input wire logic [1:0] lane_ctl,
	input wire link_cmd_t in_cmd,
	output routed_cmd_t out_cmd,
	output irq_spread_t irq_spread_select,
	output logic [31:0] credit_init
);
	logic [31:0] diag;
	logic [31:0] irq_reg;
	logic [31:0] credit;
	logic [31:0] win_en;
	logic [31:0] win_base;
	logic sample_s1;
	logic sample_s2;
	lane_sample_t link_sample;
	logic [1:0] ctl_hist0;
	logic [1:0] ctl_hist1;
	logic [1:0] ctl_hist2;
	logic link_toggle;
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic tog_s4;
	lane_sample_t cap_s1;
	lane_sample_t cap_s2;
	logic cmd_hit;
	logic [addr_width-1:0] cmd_out_addr;

	// single-word decode shared by writes and reads
	function automatic logic sel_reg(input logic [7:0] a, input logic [7:0] off);
		sel_reg = (a[7:2] == off[7:2]);
	endfunction

	wire logic wr = psel && penable && pwrite;
	wire logic known = sel_reg(paddr, diag_offset) || sel_reg(paddr, irq_offset) ||
		sel_reg(paddr, credit_offset) || sel_reg(paddr, win0_enable_offset) ||
		sel_reg(paddr, win0_base_offset);

	// zero wait states: answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known;
			if (psel && !penable && !pwrite) begin
				prdata <= sel_reg(paddr, diag_offset) ? diag :
					sel_reg(paddr, irq_offset) ? irq_reg :
					sel_reg(paddr, credit_offset) ? credit :
					sel_reg(paddr, win0_enable_offset) ? win_en :
					sel_reg(paddr, win0_base_offset) ? win_base : 32'h00000000;
			end
		end
	end

	// pready is registered from setup, so it is high exactly in the access cycle
	wire logic wr_take = wr && pready;

	// link side: sample lanes on every rising link edge while sample_s2 is set; ctl phases build up over four edges
	always_ff @(posedge link_clk or negedge link_rstn) begin
		if (!link_rstn) begin
			sample_s1 <= 1'b0;
			sample_s2 <= 1'b0;
		end else begin
			sample_s1 <= diag[sample_enable_bit];
			sample_s2 <= sample_s1;
		end
	end

	always_ff @(posedge link_clk or negedge link_rstn) begin
		if (!link_rstn) begin
			ctl_hist0 <= 2'h0;
			ctl_hist1 <= 2'h0;
			ctl_hist2 <= 2'h0;
			link_sample <= '0;
			link_toggle <= 1'b0;
		end else begin
			ctl_hist0 <= lane_ctl;
			ctl_hist1 <= ctl_hist0;
			ctl_hist2 <= ctl_hist1;
			if (sample_s2) begin // [R1] [R16]
				link_sample.cad <= lane_cad;
				link_sample.ctl0 <= {lane_ctl[0], ctl_hist0[0], ctl_hist1[0], ctl_hist2[0]};
				link_sample.ctl1 <= {lane_ctl[1], ctl_hist0[1], ctl_hist1[1], ctl_hist2[1]};
				link_toggle <= ~link_toggle;
			end
		end
	end

	// toggle handshake: the sample word is stable for a full link period after each toggle;
	// the edge is taken one stage late so cap_s2 never holds a word caught mid-change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			tog_s4 <= 1'b0;
			cap_s1 <= '0;
			cap_s2 <= '0;
		end else begin
			tog_s1 <= link_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			tog_s4 <= tog_s3;
			cap_s1 <= link_sample;
			cap_s2 <= cap_s1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag <= diag_reset;
		end else begin
			if (wr_take && sel_reg(paddr, diag_offset)) begin
				diag <= pwdata;
			end else if (diag[sample_enable_bit] && (tog_s3 != tog_s4)) begin // [R1] [R16]
				diag[cad_msb:cad_lsb] <= cap_s2.cad; // [R3]
				diag[ctl_msb:ctl_lsb] <= {cap_s2.ctl1[0], cap_s2.ctl0[0], cap_s2.ctl1[1], cap_s2.ctl0[1],
					cap_s2.ctl1[2], cap_s2.ctl0[2], cap_s2.ctl1[3], cap_s2.ctl0[3]}; // [R2]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= irq_reset;
			credit <= credit_reset; // [R5] [R6]
			win_en <= win0_enable_reset; // [R12]
			win_base <= win0_base_reset;
		end else if (wr_take) begin
			if (sel_reg(paddr, irq_offset)) begin
				irq_reg <= pwdata;
			end
			if (sel_reg(paddr, credit_offset)) begin
				credit <= pwdata;
			end
			if (sel_reg(paddr, win0_enable_offset)) begin
				win_en <= pwdata;
			end
			if (sel_reg(paddr, win0_base_offset)) begin
				win_base <= pwdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_spread_select <= spread_one;
			credit_init <= credit_reset;
		end else begin
			irq_spread_select <= irq_spread_t'(irq_reg[spread_msb:spread_lsb]); // [R4]
			credit_init <= credit;
		end
	end

	// window decode; the mask must be ones above zeros for the size to mean anything
	always_comb begin
		cmd_hit = win_en[win_enable_bit] && // [R15]
			((win_base[base_msb:base_lsb] & win_base[mask_msb:0]) ==
			(in_cmd.addr[addr_win_msb:addr_win_lsb] & win_base[mask_msb:0])); // [R7] [R14] [R9]
		cmd_out_addr = in_cmd.addr;
		if (win_en[win_translate_bit]) begin // [R8] [R13]
			cmd_out_addr[addr_width-1:addr_win_lsb] = win_en[trans_msb:0];
			cmd_out_addr[addr_win_msb:addr_win_lsb] = win_en[addr_win_msb-addr_win_lsb:0] |
				(in_cmd.addr[addr_win_msb:addr_win_lsb] & ~win_base[mask_msb:0]);
		end
	end

	// command path is on pclk; an unmatched command returns to the link untranslated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_cmd <= '0;
		end else begin
			out_cmd.valid <= in_cmd.valid;
			out_cmd.to_cpu <= cmd_hit; // [R10] [R11] [R15]
			out_cmd.addr <= cmd_hit ? cmd_out_addr : in_cmd.addr;
		end
	end
endmodule
`default_nettype wire

/* File: shared/link_rx_pkg.sv */
// package: register map, field layout and types of the link receive window block
package link_rx_pkg;
	localparam logic [7:0] diag_offset = 8'h54;
	localparam logic [7:0] irq_offset = 8'h58;
	localparam logic [7:0] credit_offset = 8'h5c;
	localparam logic [7:0] win0_enable_offset = 8'h60;
	localparam logic [7:0] win0_base_offset = 8'h64;
	localparam logic [31:0] diag_reset = 32'h00000000;
	localparam logic [31:0] irq_reset = 32'h00000000;
	localparam logic [31:0] credit_reset = 32'h07778888;
	localparam logic [31:0] win0_enable_reset = 32'h00000000;
	localparam logic [31:0] win0_base_reset = 32'h00000000;
	localparam int sample_enable_bit = 0;
	localparam int ctl_lsb = 8;
	localparam int ctl_msb = 15;
	localparam int cad_lsb = 16;
	localparam int cad_msb = 31;
	localparam int spread_lsb = 8;
	localparam int spread_msb = 9;
	localparam int win_enable_bit = 31;
	localparam int win_translate_bit = 30;
	localparam int trans_msb = 29;
	localparam int base_lsb = 16;
	localparam int base_msb = 31;
	localparam int mask_msb = 15;
	localparam int addr_win_lsb = 24;
	localparam int addr_win_msb = 39;
	localparam int addr_width = 54;

	typedef enum logic [1:0] {
		spread_one = 2'h0,
		spread_two = 2'h1,
		spread_four = 2'h2
	} irq_spread_t;

	typedef struct packed {
		logic [15:0] cad;
		logic [3:0] ctl0;
		logic [3:0] ctl1;
	} lane_sample_t;

	typedef struct packed {
		logic valid;
		logic [addr_width-1:0] addr;
	} link_cmd_t;

	typedef struct packed {
		logic valid;
		logic to_cpu;
		logic [addr_width-1:0] addr;
	} routed_cmd_t;
endpackage

/* File: verification/link_peer.sv */
// link peer model: drives the lane pattern on the link clock
`timescale 1ns/1ps
`default_nettype none
module link_peer (
	input wire logic link_clk,
	input wire logic [15:0] cad_val,
	input wire logic [1:0] ctl_val,
	output logic [15:0] lane_cad,
	output logic [1:0] lane_ctl
);
	// lanes move only after a link edge so the receiver never samples mid-change
	always_ff @(posedge link_clk) begin
		lane_cad <= cad_val;
		lane_ctl <= ctl_val;
	end
endmodule
`default_nettype wire

/* File: verification/link_rx_sva.sv */
// checker: bus, routing and register copy properties of the receive window block
`timescale 1ns/1ps
`default_nettype none
module link_rx_sva
	import link_rx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire link_cmd_t in_cmd,
	input wire routed_cmd_t out_cmd,
	input wire irq_spread_t irq_spread_select,
	input wire logic [31:0] credit_init
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_unmapped_err: assert property (psel && !penable && paddr == 8'h00 |=> pslverr) else $error("no error");
	a_cmd_latency: assert property (in_cmd.valid |=> out_cmd.valid) else $error("command lost");
	a_no_spurious: assert property (!in_cmd.valid |=> !out_cmd.valid) else $error("spurious command");
	a_miss_passthru: assert property (in_cmd.valid |=> out_cmd.to_cpu || out_cmd.addr == $past(in_cmd.addr))
		else $error("miss address changed");
	a_credit_reset: assert property ($rose(presetn) |-> credit_init == 32'h07778888) else $error("credit reset");
	a_spread_copy: assert property (psel && penable && pready && pwrite && paddr == 8'h58
		|=> ##1 irq_spread_select == $past(pwdata[9:8], 2)) else $error("spread copy");
	a_credit_copy: assert property (psel && penable && pready && pwrite && paddr == 8'h5c
		|=> ##1 credit_init == $past(pwdata, 2)) else $error("credit copy");
endmodule
bind link_rx_window link_rx_sva u_link_rx_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .in_cmd, .out_cmd, .irq_spread_select, .credit_init);
`default_nettype wire

/* File: verification/tb_top.sv */
// testbench: register access, window routing and lane capture scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import link_rx_pkg::*;
	logic pclk = 0, link_clk = 0, presetn = 0, link_rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, credit_init, rd;
	logic pready, pslverr, err;
	logic [15:0] cad_val = 16'h0, lane_cad;
	logic [1:0] ctl_val = 2'h0, lane_ctl;
	link_cmd_t in_cmd = '0;
	routed_cmd_t out_cmd;
	irq_spread_t irq_spread_select;
	int bad_count = 0, num_checks = 0, cyc = 0;
	always #2 pclk = ~pclk;
	// odd offset puts every link clock edge 1 ns after a core clock rising edge, never on one
	initial #7 forever #40 link_clk = ~link_clk;
	link_rx_window u_link_rx_window (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .link_clk, .link_rstn, .lane_cad, .lane_ctl, .in_cmd, .out_cmd, .irq_spread_select, .credit_init);
	link_peer u_link_peer (.link_clk, .cad_val, .ctl_val, .lane_cad, .lane_ctl);
	task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", bad_count, num_checks);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", pready, 1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 0);
		chk(name, rd, exp);
	endtask
	task automatic cmd(input logic [53:0] a, input logic cpu, input logic [53:0] exp);
		@(posedge pclk);
		in_cmd <= '{1'b1, a};
		@(posedge pclk);
		in_cmd <= '0;
		#1 chk("cmd_valid", out_cmd.valid, 1);
		chk("cmd_cpu", out_cmd.to_cpu, cpu);
		chk("cmd_addr", out_cmd.addr, exp);
	endtask
	task automatic t_reset;
		rchk("diag", 8'h54, 32'h0);
		rchk("irq", 8'h58, 32'h0);
		rchk("credit", 8'h5c, 32'h07778888);
		rchk("win_en", 8'h60, 32'h0);
		chk("credit_out", credit_init, 32'h07778888);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 3; i++) begin
			apb(1, 8'h58, {22'h0, i[1:0], 8'h00});
			repeat (2) @(posedge pclk);
			chk("spread", irq_spread_select, i);
		end
		apb(1, 8'h5c, 32'h01234567);
		repeat (2) @(posedge pclk);
		chk("credit_copy", credit_init, 32'h01234567);
		rchk("credit_rd", 8'h5c, 32'h01234567);
		apb(1, 8'h00, 32'hffffffff);
		chk("unmapped_err", err, 1);
		rchk("unmapped_rd", 8'h00, 32'h0);
	endtask
	task automatic t_window;
		logic [53:0] a = 54'h1_0015_123456;
		cmd(a, 0, a);
		apb(1, 8'h64, 32'h0012fff0);
		apb(1, 8'h60, 32'h80000300);
		cmd(a, 1, a);
		cmd(54'h1_0025_123456, 0, 54'h1_0025_123456);
		apb(1, 8'h60, 32'hc0000300);
		cmd(a, 1, {30'h305, a[23:0]});
	endtask
	task automatic t_diag;
		cad_val <= 16'habcd;
		ctl_val <= 2'h1;
		apb(1, 8'h54, 32'h1);
		repeat (20) @(posedge link_clk);
		rchk("diag_on", 8'h54, 32'habcd5501);
		// same fields as the lanes, so a capture still in flight cannot disturb it
		apb(1, 8'h54, 32'habcd5500);
		repeat (5) @(posedge link_clk);
		cad_val <= 16'h5a5a;
		ctl_val <= 2'h2;
		repeat (20) @(posedge link_clk);
		rchk("diag_off", 8'h54, 32'habcd5500);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		link_rstn <= 1;
		t_reset();
		t_regs();
		t_window();
		t_diag();
		print_verdict();
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
endmodule
`default_nettype wire
